// *** design/qis_pkg.sv ***
package qis_pkg;

  // Structure
  localparam int QIS_PORTS = 4;
  localparam int QIS_ADDR_W = 6;
  localparam int QIS_FIFO_WORDS = 128;
  localparam int QIS_AREA_WORDS = 32;
  localparam int QIS_SAMPLE_BITS = 16;
  localparam int QIS_WM_W = 6;

  // Register byte offsets inside the 64-byte region
  localparam logic [5:0] QIS_OFS_CTRL = 6'h00;
  localparam logic [5:0] QIS_OFS_IRQ_STAT = 6'h04;
  localparam logic [5:0] QIS_OFS_IRQ_MASK = 6'h08;
  localparam logic [5:0] QIS_OFS_FIFO_STAT = 6'h0c;
  localparam logic [5:0] QIS_OFS_WMARK = 6'h10;
  localparam logic [5:0] QIS_OFS_DATA0 = 6'h20;

  // Control register field positions
  localparam int QIS_CTRL_MASTER_LSB = 8;
  localparam int QIS_CTRL_ALT_LSB = 12;
  localparam int QIS_CTRL_DIR_LSB = 20;

  // Reset values
  localparam logic [3:0] QIS_CTRL_FIELD_RST = 4'h0;
  localparam logic [7:0] QIS_IRQ_MASK_RST = 8'h00;
  localparam logic [23:0] QIS_WMARK_RST = 24'h000000;

  // Bus answers
  localparam logic [1:0] QIS_RESP_OKAY = 2'h0;
  localparam logic [1:0] QIS_RESP_SLVERR = 2'h2;
  localparam logic [3:0] QIS_STRB_FULL = 4'hf;

  typedef struct packed {
    logic dir;
    logic master;
    logic alt;
  } qis_cfg_type;

  typedef struct packed {
    logic [15:0] left;
    logic [15:0] right;
  } qis_frame_type;

endpackage

// *** design/qis_port.sv ***
module qis_port
  import qis_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Configuration
  input wire qis_cfg_type cfg,
  // Sampled serial side
  input wire logic sck_rise,
  input wire logic sck_fall,
  input wire logic ws_in,
  input wire logic sdi,
  output logic sdo,
  output logic ws_out,
  // Word side
  output logic rx_valid,
  output qis_frame_type rx_word,
  input wire qis_frame_type tx_word,
  input wire logic tx_avail,
  output logic tx_take
);

  logic [4:0] gen_cnt_ff;
  logic [4:0] nxt_gen_cnt;
  logic ws_gen_ff;
  logic ws_prev_ff;
  logic [4:0] idx_ff;
  logic chan_right_ff;
  logic [15:0] shift_ff;
  logic [15:0] nxt_sample;
  logic left_done_ff;
  qis_frame_type rx_ff;
  qis_frame_type tx_ff;
  logic sdo_ff;
  logic rx_valid_ff;
  logic tx_take_ff;
  logic ws_used;
  logic is_right;
  logic ws_change;
  logic [3:0] bit_pos;

  assign ws_used = cfg.master ? ws_gen_ff : ws_in;
  assign is_right = ws_used ^ cfg.alt;
  assign ws_change = sck_rise && (ws_used != ws_prev_ff);
  assign nxt_gen_cnt = gen_cnt_ff + 5'h01;
  assign nxt_sample = {shift_ff[14:0], sdi};
  assign bit_pos = 4'(QIS_SAMPLE_BITS - 1) - idx_ff[3:0];

  // master select generated on core clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gen_cnt_ff <= 5'h00;
      ws_gen_ff <= 1'b0;
    end
    else if (sck_fall)
    begin
      gen_cnt_ff <= nxt_gen_cnt;
      ws_gen_ff <= nxt_gen_cnt[4];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_prev_ff <= 1'b0;
      idx_ff <= 5'h00;
      chan_right_ff <= 1'b0;
      shift_ff <= 16'h0000;
    end
    else if (ws_change)
    begin
      ws_prev_ff <= ws_used;
      idx_ff <= 5'h00;
      chan_right_ff <= is_right;
    end
    else if (sck_rise && idx_ff < 5'(QIS_SAMPLE_BITS))
    begin
      shift_ff <= nxt_sample;
      idx_ff <= idx_ff + 5'h01;
    end
  end

  // Word completes on the last right-channel bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_ff <= '0;
      left_done_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
    end
    else
    begin
      rx_valid_ff <= 1'b0;
      if (sck_rise && !ws_change && idx_ff == 5'(QIS_SAMPLE_BITS - 1))
      begin
        if (chan_right_ff)
        begin
          rx_ff.right <= nxt_sample;
          left_done_ff <= 1'b0;
          rx_valid_ff <= left_done_ff && cfg.dir;
        end
        else
        begin
          rx_ff.left <= nxt_sample;
          left_done_ff <= 1'b1;
        end
      end
    end
  end

  // Underrun sends silence rather than stale data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_ff <= '0;
      tx_take_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end
    else
    begin
      tx_take_ff <= 1'b0;
      if (ws_change && !is_right)
      begin
        tx_ff <= tx_avail ? tx_word : '0;
        tx_take_ff <= tx_avail && !cfg.dir;
      end
      if (sck_fall)
      begin
        if (!cfg.dir && idx_ff < 5'(QIS_SAMPLE_BITS))
          sdo_ff <= chan_right_ff ? tx_ff.right[bit_pos] : tx_ff.left[bit_pos];
        else
          sdo_ff <= 1'b0;
      end
    end
  end

  assign sdo = sdo_ff;
  assign ws_out = ws_gen_ff;
  assign rx_valid = rx_valid_ff;
  assign rx_word = rx_ff;
  assign tx_take = tx_take_ff;

endmodule // qis_port

// *** design/qis_top.sv ***
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
module qis_top
  import qis_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [QIS_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [QIS_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Serial pins
  input wire logic sck,
  input wire logic [QIS_PORTS-1:0] word_select_input,
  input wire logic [QIS_PORTS-1:0] serial_data_input,
  output logic [QIS_PORTS-1:0] serial_data_output,
  output logic [QIS_PORTS-1:0] word_select_output,
  // Buffer direction controls
  output logic [QIS_PORTS-1:0] data_dir,
  output logic [QIS_PORTS-1:0] ws_dir,
  // Interrupts
  output logic int_r,
  output logic int_w,
  output logic irq
);

  localparam int PW = $clog2(QIS_AREA_WORDS);
  localparam int SYNC_W = 1 + 2 * QIS_PORTS;

  function automatic logic [2:0] first_set(input logic [3:0] req);
    first_set = 3'h0;
    for (int i = QIS_PORTS - 1; i >= 0; i--)
      if (req[i])
        first_set = {1'b1, 2'(i)};
  endfunction

  function automatic logic is_data(input logic [QIS_ADDR_W-1:0] a);
    is_data = (a[5:4] == QIS_OFS_DATA0[5:4]) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic addr_ok(input logic [QIS_ADDR_W-1:0] a);
    addr_ok = is_data(a) || a == QIS_OFS_CTRL || a == QIS_OFS_IRQ_STAT ||
              a == QIS_OFS_IRQ_MASK || a == QIS_OFS_FIFO_STAT || a == QIS_OFS_WMARK;
  endfunction

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic sck_prev_ff;
  logic sck_rise;
  logic sck_fall;

  logic [QIS_PORTS-1:0] dir_ff;
  logic [QIS_PORTS-1:0] master_ff;
  logic [QIS_PORTS-1:0] alt_ff;
  logic [7:0] irq_stat_ff;
  logic [7:0] irq_mask_ff;
  logic [23:0] wmark_ff;
  logic int_r_ff;
  logic int_w_ff;
  logic [QIS_PORTS-1:0] lvl_ff;
  logic [QIS_PORTS-1:0] lvl;
  logic [QIS_PORTS-1:0] ev;
  logic [7:0] stat_clr;

  logic [31:0] mem [QIS_FIFO_WORDS];
  logic [PW-1:0] wr_ptr_ff [QIS_PORTS];
  logic [PW-1:0] rd_ptr_ff [QIS_PORTS];
  logic [PW:0] count_ff [QIS_PORTS];
  logic [QIS_PORTS-1:0] rxp_valid_ff;
  qis_frame_type rxp_word_ff [QIS_PORTS];
  logic [QIS_PORTS-1:0] txh_valid_ff;
  qis_frame_type txh_word_ff [QIS_PORTS];

  qis_cfg_type cfg [QIS_PORTS];
  logic [QIS_PORTS-1:0] rx_valid;
  qis_frame_type rx_word [QIS_PORTS];
  logic [QIS_PORTS-1:0] tx_take;

  logic [QIS_PORTS-1:0] full;
  logic [QIS_PORTS-1:0] empty;
  logic [QIS_PORTS-1:0] wr_req;
  logic [QIS_PORTS-1:0] rd_req;
  logic wr_srv;
  logic [1:0] wr_srv_idx;
  logic rd_srv;
  logic [1:0] rd_srv_idx;
  logic fifo_we;
  logic [1:0] wport;
  logic [31:0] fifo_wdata;
  logic fifo_re;
  logic [1:0] rport;
  logic [31:0] rd_word;

  logic aw_got_ff;
  logic [QIS_ADDR_W-1:0] wa_ff;
  logic w_got_ff;
  logic [31:0] wd_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rd_pend_ff;
  logic [QIS_ADDR_W-1:0] ra_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_go;
  logic wr_exec;
  logic wr_ok;
  logic bus_push;
  logic rd_exec;
  logic bus_pop;
  logic [1:0] bus_wport;
  logic [1:0] bus_rport;
  logic [31:0] rd_val;

  // serial pins pass two core-clock stages
  assign pin_raw = {sck, word_select_input, serial_data_input};
  genvar g;
  for (g = 0; g < SYNC_W; g++)
  begin : g_sync
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta_ff[g] <= 1'b0;
        sync_ff[g] <= 1'b0;
      end
      else
      begin
        meta_ff[g] <= pin_raw[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  end

  // edges of the sampled serial clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sck_prev_ff <= 1'b0;
    else
      sck_prev_ff <= sync_ff[SYNC_W-1];
  end
  assign sck_rise = sync_ff[SYNC_W-1] && !sck_prev_ff;
  assign sck_fall = !sync_ff[SYNC_W-1] && sck_prev_ff;

  // four ports on one serial clock
  for (g = 0; g < QIS_PORTS; g++)
  begin : g_port
    assign cfg[g] = '{dir: dir_ff[g], master: master_ff[g], alt: alt_ff[g]};
    qis_port u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg[g]),
      .sck_rise(sck_rise),
      .sck_fall(sck_fall),
      .ws_in(sync_ff[QIS_PORTS+g]),
      .sdi(sync_ff[g]),
      .sdo(serial_data_output[g]),
      .ws_out(word_select_output[g]),
      .rx_valid(rx_valid[g]),
      .rx_word(rx_word[g]),
      .tx_word(txh_word_ff[g]),
      .tx_avail(txh_valid_ff[g]),
      .tx_take(tx_take[g])
    );
  end

  // serial side has priority over the bus
  always_comb
  begin
    for (int p = 0; p < QIS_PORTS; p++)
    begin
      full[p] = count_ff[p] == (PW + 1)'(QIS_AREA_WORDS);
      empty[p] = count_ff[p] == '0;
      wr_req[p] = rxp_valid_ff[p] && !full[p];
      rd_req[p] = !dir_ff[p] && !txh_valid_ff[p] && !empty[p];
    end
    {wr_srv, wr_srv_idx} = first_set(wr_req);
    {rd_srv, rd_srv_idx} = first_set(rd_req);
  end

  assign bus_wport = wa_ff[3:2];
  assign bus_rport = ra_ff[3:2];
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_exec = wr_go && !(is_data(wa_ff) && wr_srv);
  assign wr_ok = addr_ok(wa_ff) && wstrb_ff == QIS_STRB_FULL &&
                 !(is_data(wa_ff) && !dir_ff[bus_wport] && full[bus_wport]);
  assign bus_push = wr_exec && wr_ok && is_data(wa_ff) && !dir_ff[bus_wport];
  assign rd_exec = rd_pend_ff && !(is_data(ra_ff) && rd_srv);
  assign bus_pop = rd_exec && is_data(ra_ff) && dir_ff[bus_rport] && !empty[bus_rport];

  assign fifo_we = wr_srv || bus_push;
  assign wport = wr_srv ? wr_srv_idx : bus_wport;
  assign fifo_wdata = wr_srv ? rxp_word_ff[wr_srv_idx] : wd_ff;
  assign fifo_re = rd_srv || bus_pop;
  assign rport = rd_srv ? rd_srv_idx : bus_rport;
  assign rd_word = mem[{rport, rd_ptr_ff[rport]}];

  always_ff @(posedge aclk)
  begin
    if (fifo_we)
      mem[{wport, wr_ptr_ff[wport]}] <= fifo_wdata;
  end

  for (g = 0; g < QIS_PORTS; g++)
  begin : g_area
    logic do_wr;
    logic do_rd;
    assign do_wr = fifo_we && wport == 2'(g);
    assign do_rd = fifo_re && rport == 2'(g);

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        wr_ptr_ff[g] <= '0;
        rd_ptr_ff[g] <= '0;
        count_ff[g] <= '0;
      end
      else
      begin
        if (do_wr)
          wr_ptr_ff[g] <= wr_ptr_ff[g] + 1'b1;
        if (do_rd)
          rd_ptr_ff[g] <= rd_ptr_ff[g] + 1'b1;
        if (do_wr && !do_rd)
          count_ff[g] <= count_ff[g] + 1'b1;
        else if (do_rd && !do_wr)
          count_ff[g] <= count_ff[g] - 1'b1;
      end
    end

    // A word left waiting is overwritten by the next one
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        rxp_valid_ff[g] <= 1'b0;
        rxp_word_ff[g] <= '0;
        txh_valid_ff[g] <= 1'b0;
        txh_word_ff[g] <= '0;
      end
      else
      begin
        if (rx_valid[g])
        begin
          rxp_valid_ff[g] <= 1'b1;
          rxp_word_ff[g] <= rx_word[g];
        end
        else if (wr_srv && wr_srv_idx == 2'(g))
          rxp_valid_ff[g] <= 1'b0;
        if (rd_srv && rd_srv_idx == 2'(g))
        begin
          txh_valid_ff[g] <= 1'b1;
          txh_word_ff[g] <= rd_word;
        end
        else if (tx_take[g])
          txh_valid_ff[g] <= 1'b0;
      end
    end
  end

  always_comb
  begin
    for (int p = 0; p < QIS_PORTS; p++)
    begin
      if (dir_ff[p])
        lvl[p] = count_ff[p] > wmark_ff[p*QIS_WM_W +: QIS_WM_W];
      else
        lvl[p] = count_ff[p] < wmark_ff[p*QIS_WM_W +: QIS_WM_W];
    end
    ev = lvl & ~lvl_ff;
    stat_clr = (rd_exec && ra_ff == QIS_OFS_IRQ_STAT) ? irq_stat_ff : 8'h00;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lvl_ff <= '0;
      irq_stat_ff <= 8'h00;
      int_r_ff <= 1'b0;
      int_w_ff <= 1'b0;
    end
    else
    begin
      lvl_ff <= lvl;
      // New events win over the read clear
      irq_stat_ff <= (irq_stat_ff & ~stat_clr) | {ev & dir_ff, ev & ~dir_ff};
      // one-cycle pulses; adjacent events merge, status keeps both
      int_w_ff <= |(ev & ~dir_ff & irq_mask_ff[3:0]) && !int_w_ff;
      int_r_ff <= |(ev & dir_ff & irq_mask_ff[7:4]) && !int_r_ff;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dir_ff <= QIS_CTRL_FIELD_RST;
      master_ff <= QIS_CTRL_FIELD_RST;
      alt_ff <= QIS_CTRL_FIELD_RST;
      irq_mask_ff <= QIS_IRQ_MASK_RST;
      wmark_ff <= QIS_WMARK_RST;
    end
    else if (wr_exec && wr_ok)
    begin
      if (wa_ff == QIS_OFS_CTRL)
      begin
        dir_ff <= wd_ff[QIS_CTRL_DIR_LSB +: QIS_PORTS];
        master_ff <= wd_ff[QIS_CTRL_MASTER_LSB +: QIS_PORTS];
        alt_ff <= wd_ff[QIS_CTRL_ALT_LSB +: QIS_PORTS];
      end
      if (wa_ff == QIS_OFS_IRQ_MASK)
        irq_mask_ff <= wd_ff[7:0];
      if (wa_ff == QIS_OFS_WMARK)
        wmark_ff <= wd_ff[23:0];
    end
  end

  // Write channels accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      wa_ff <= '0;
      w_got_ff <= 1'b0;
      wd_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= QIS_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_ff <= 1'b1;
        wa_ff <= awaddr;
      end
      else if (wr_exec)
        aw_got_ff <= 1'b0;
      if (wvalid && wready)
      begin
        w_got_ff <= 1'b1;
        wd_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      else if (wr_exec)
        w_got_ff <= 1'b0;
      if (wr_exec)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? QIS_RESP_OKAY : QIS_RESP_SLVERR;
      end
      else if (bready)
        bvalid_ff <= 1'b0;
    end
  end

  always_comb
  begin
    rd_val = 32'h00000000;
    if (is_data(ra_ff))
      rd_val = bus_pop ? rd_word : 32'h00000000;
    else if (ra_ff == QIS_OFS_CTRL)
    begin
      rd_val[QIS_CTRL_DIR_LSB +: QIS_PORTS] = dir_ff;
      rd_val[QIS_CTRL_MASTER_LSB +: QIS_PORTS] = master_ff;
      rd_val[QIS_CTRL_ALT_LSB +: QIS_PORTS] = alt_ff;
    end
    else if (ra_ff == QIS_OFS_IRQ_STAT)
      rd_val[7:0] = irq_stat_ff;
    else if (ra_ff == QIS_OFS_IRQ_MASK)
      rd_val[7:0] = irq_mask_ff;
    else if (ra_ff == QIS_OFS_WMARK)
      rd_val[23:0] = wmark_ff;
    else if (ra_ff == QIS_OFS_FIFO_STAT)
    begin
      for (int p = 0; p < QIS_PORTS; p++)
        rd_val[p*4 +: 4] = {txh_valid_ff[p], full[p],
                            count_ff[p] >= (PW + 1)'(QIS_AREA_WORDS / 2), empty[p]};
    end
  end

  // Data reads wait while a port refill holds the read port
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend_ff <= 1'b0;
      ra_ff <= '0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= QIS_RESP_OKAY;
    end
    else
    begin
      if (arvalid && arready)
      begin
        rd_pend_ff <= 1'b1;
        ra_ff <= araddr;
      end
      else if (rd_exec)
      begin
        rd_pend_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_val;
        rresp_ff <= addr_ok(ra_ff) ? QIS_RESP_OKAY : QIS_RESP_SLVERR;
      end
      else if (rready)
        rvalid_ff <= 1'b0;
    end
  end

  assign awready = !aw_got_ff && !bvalid_ff;
  assign wready = !w_got_ff && !bvalid_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = !rd_pend_ff && !rvalid_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign data_dir = dir_ff;
  assign ws_dir = master_ff;
  assign int_r = int_r_ff;
  assign int_w = int_w_ff;
  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule // qis_top

// *** dv/qis_top_monitor.sv ***
module qis_top_monitor
  import qis_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic rvalid,
  // Serial side
  input wire logic sck,
  input wire logic [QIS_PORTS-1:0] serial_data_output,
  input wire logic [QIS_PORTS-1:0] word_select_output,
  // Buffer controls and interrupts
  input wire logic [QIS_PORTS-1:0] data_dir,
  input wire logic [QIS_PORTS-1:0] ws_dir,
  input wire logic int_r,
  input wire logic int_w,
  input wire logic irq
);
  logic [4:0] falls_ff;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pin falls since the last generated select toggle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !$stable(word_select_output[2]))
      falls_ff <= 5'h00;
    else if ($fell(sck))
      falls_ff <= falls_ff + 5'h01;
  end

  reset_clear_a: assert property (
    $rose(aresetn) |-> !data_dir && !ws_dir && !irq && !int_r && !int_w)
    else $error("control outputs not cleared by reset");
  dir_write_a: assert property (
    !$stable(data_dir) |-> bvalid && bresp == QIS_RESP_OKAY)
    else $error("direction bits moved without a register write");
  master_write_a: assert property (
    !$stable(ws_dir) |-> bvalid && bresp == QIS_RESP_OKAY)
    else $error("master bits moved without a register write");
  irq_rise_a: assert property (
    $rose(irq) |-> bvalid || int_r || int_w)
    else $error("irq rose without event or mask write");
  irq_fall_a: assert property (
    $fell(irq) |-> rvalid || $past(rvalid) || bvalid)
    else $error("irq fell without status read or mask write");
  read_pulse_a: assert property (int_r |=> !int_r)
    else $error("read interrupt longer than one cycle");
  write_pulse_a: assert property (int_w |=> !int_w)
    else $error("write interrupt longer than one cycle");
  sdo_timing_a: assert property (
    !$stable(serial_data_output) |-> (!sck && $past(!sck)) || bvalid || $past(bvalid))
    else $error("serial data changed outside a serial clock low phase");
  ws_period_a: assert property (
    !$stable(word_select_output[2]) |-> falls_ff == 5'h10 && !sck)
    else $error("generated select not toggled after sixteen falls");
endmodule // qis_top_monitor

bind qis_top qis_top_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .bresp(bresp), .bvalid(bvalid), .rvalid(rvalid),
  .sck(sck), .serial_data_output(serial_data_output),
  .word_select_output(word_select_output), .data_dir(data_dir), .ws_dir(ws_dir),
  .int_r(int_r), .int_w(int_w), .irq(irq)
);

// *** dv/qis_codec_model.sv ***
module qis_codec_model (
  // Serial pins
  output logic sck,
  output logic [3:0] ws,
  output logic [3:0] sdi,
  input wire logic [3:0] sdo,
  // Halves heard from port 3
  output logic [17:0] cap_l,
  output logic [17:0] cap_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] sh;

  initial
  begin
    sck = 1'b0;
    ws = 4'hf;
    sdi = 4'h5;
    cap_l = 18'h0;
    cap_r = 18'h0;
  end

  task automatic half(input logic lvl, input logic [15:0] d);
    ws = {4{lvl}};
    sdi = ~sdi;
    #40 sck = 1'b1;
    #40 sck = 1'b0;
    for (int i = 17; i >= 0; i--)
    begin
      // Two junk bits after the LSB must be ignored
      sdi = (i > 1) ? {4{d[i-2]}} : ~sdi;
      #40 sck = 1'b1;
      sh = {sh[16:0], sdo[3]};
      #40 sck = 1'b0;
    end
  endtask

  // Clock stands low between frames; idle data toggles
  task automatic frame(input logic a, input logic [31:0] w);
    #1.3;
    half(~a, 16'h0);
    half(a, w[31:16]);
    cap_l = sh;
    half(~a, w[15:0]);
    cap_r = sh;
    sdi = ~sdi;
  endtask
endmodule // qis_codec_model

// *** dv/qis_top_test.sv ***
module qis_top_test
  import qis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, sck, int_r, int_w, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ws, sdi, sdo, ws_o, ddir, wdir;
  logic [17:0] cap_l, cap_r;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int fails = 0;
  int cmp_count = 0;
  int nr, nw;
  int seed = 61013;

  always #2 aclk = ~aclk;

  qis_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sck(sck), .word_select_input(ws), .serial_data_input(sdi),
    .serial_data_output(sdo), .word_select_output(ws_o), .data_dir(ddir),
    .ws_dir(wdir), .int_r(int_r), .int_w(int_w), .irq(irq)
  );

  qis_codec_model i_codec (
    .sck(sck), .ws(ws), .sdi(sdi), .sdo(sdo), .cap_l(cap_l), .cap_r(cap_r)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    exp_b.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask

  task automatic rd(input logic [5:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Oldest expectation meets each bus answer
  always @(posedge aclk)
  begin
    nr += int_r;
    nw += int_w;
    if (bvalid && bready) chk(bresp, exp_b.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, exp_r.pop_front());
  end

  initial
  begin
    repeat (10000) @(posedge aclk);
    fails++;
    summarize();
  end

  initial
  begin
    logic [31:0] v;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({ddir, wdir, int_r, int_w, irq}, 11'h0);
    rd(QIS_OFS_CTRL, 34'h0);
    rd(QIS_OFS_IRQ_MASK, 34'h0);
    rd(6'h3c, {QIS_RESP_SLVERR, 32'h0});
    rd(6'h02, {QIS_RESP_SLVERR, 32'h0});
    wr(6'h34, 32'h1, QIS_RESP_SLVERR);
    $display("test reset_decode done");
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed);
      wr(QIS_OFS_CTRL, v, QIS_RESP_OKAY);
      rd(QIS_OFS_CTRL, {2'h0, v & 32'h00f0ff00});
      chk({ddir, wdir}, {v[23:20], v[11:8]});
      wr(QIS_OFS_IRQ_MASK, ~v, QIS_RESP_OKAY);
      rd(QIS_OFS_IRQ_MASK, {26'h0, ~v[7:0]});
    end
    $display("test control_regs done");
    // Ports 0,1 in, 2 master out, 3 slave out; second frame masked
    for (int k = 0; k < 2; k++)
    begin
      v = $random(seed);
      nr = 0;
      nw = 0;
      wr(QIS_OFS_IRQ_MASK, {24'h0, k ? 8'h00 : 8'hff}, QIS_RESP_OKAY);
      wr(QIS_OFS_WMARK, 32'h00040000, QIS_RESP_OKAY);
      rd(QIS_OFS_WMARK, 34'h000040000);
      wr(QIS_OFS_CTRL, k ? 32'h0030f400 : 32'h00300400, QIS_RESP_OKAY);
      if (k == 0) wr(QIS_OFS_DATA0 + 6'h0c, ~v, QIS_RESP_OKAY);
      i_codec.frame(k[0], v);
      repeat (20) @(posedge aclk);
      chk({cap_l, cap_r}, k ? 36'h0 : {~v[31:16], 2'h0, ~v[15:0], 2'h0});
      chk({sdo[1:0], irq, nr != 0, nw != 0}, {2'h0, k == 0, k == 0, k == 0});
      rd(QIS_OFS_DATA0, {2'h0, v});
      rd(QIS_OFS_DATA0 + 6'h04, {2'h0, v});
      rd(QIS_OFS_DATA0, 34'h0);
      rd(QIS_OFS_DATA0 + 6'h0c, 34'h0);
      if (k == 1) wr(QIS_OFS_IRQ_MASK, 32'hff, QIS_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      rd(QIS_OFS_IRQ_STAT, {2'h0, k ? 32'h30 : 32'h38});
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      rd(QIS_OFS_IRQ_STAT, 34'h0);
      $display("test frame %0d done", k);
    end
    // Let the answer checker see the last response first
    repeat (2) @(posedge aclk);
    chk(exp_r.size() + exp_b.size(), 0);
    summarize();
  end
endmodule // qis_top_test
